// [alog_pkg.sv]
// Constants of the alarm log and bus LED block: register map, field
// positions, message types, bus states and LED timing.
// Assumes a 25 MHz device clock and a 32-bit register bus.
package alog_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFF = 8'h00;
  localparam logic [7:0] COUNT_OFF = 8'h04;
  localparam logic [7:0] LATEST_OFF = 8'h08;
  localparam logic [7:0] SEL_OFF = 8'h0C;
  localparam logic [7:0] ECODE_OFF = 8'h10;
  localparam logic [7:0] EFIX_OFF = 8'h14;
  localparam logic [7:0] EFLT_OFF = 8'h18;
  localparam logic [7:0] REMAP_OFF = 8'h40;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int STATUS_ALARM_BIT = 7;
  localparam int ECODE_REMOVED_BIT = 16;
  localparam int ECODE_VALID_BIT = 17;
  localparam int REMAP_TYPE_LSB = 16;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Storage sizes
  // ----------------------------------------------------------------
  localparam int BUF_DEPTH = 8;
  localparam int HIST_DEPTH = 56;
  localparam int HIST_BASE = 8;
  localparam int REMAP_DEPTH = 20;
  localparam int OVERWRITE_IDX = 6;

  // ----------------------------------------------------------------
  // Message types and bus states
  // ----------------------------------------------------------------
  localparam logic [1:0] MSG_FAULT = 2'h1;
  localparam logic [1:0] MSG_ALARM = 2'h2;
  localparam logic [1:0] MSG_NONE = 2'h3;
  localparam logic [1:0] CAN_STOPPED = 2'h0;
  localparam logic [1:0] CAN_PREOP = 2'h1;
  localparam logic [1:0] CAN_OPER = 2'h2;

  // ----------------------------------------------------------------
  // LED timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_MS = 50;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FRAME_TICKS = 40;
  localparam int SLOW_HALF = 10;
  localparam int FAST_HALF = 2;
  localparam int FLASH_TICKS = 4;

  typedef struct packed {
    logic valid;
    logic removed;
    logic [15:0] code;
    logic [31:0] fixed;
    logic [31:0] flt;
  } alog_entry_t;

endpackage

// [alog_top.sv]
// Alarm buffer, alarm history, remap table and CANopen bus/ready LEDs.
// Assumes event inputs come from logic on clk and an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none

module alog_top #(
  parameter int TICK_CYCLES = alog_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Alarm sources
  input wire logic alarm_raise,
  input wire logic alarm_gone,
  input wire logic [15:0] alarm_code,
  input wire logic [31:0] alarm_value_fixed,
  input wire logic [31:0] alarm_value_float,
  output logic alarm_ready,
  output logic alarm_active,
  output logic fault_raise,
  output logic [15:0] fault_code,
  // Bus controller and device states
  input wire logic [1:0] can_state,
  input wire logic no_bus,
  input wire logic alarm_limit,
  input wire logic error_control_event,
  input wire logic fw_updating,
  input wire logic fw_wait_power,
  input wire logic fw_failed,
  input wire logic bad_card,
  // LEDs
  output logic bus_fault_led_red,
  output logic bus_fault_led_green,
  output logic ready_led_red,
  output logic ready_led_green
);

  typedef enum {LG_IDLE, LG_SCAN, LG_FINISH} alog_state_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  alog_pkg::alog_entry_t abuf [alog_pkg::BUF_DEPTH];
  alog_pkg::alog_entry_t next_abuf [alog_pkg::BUF_DEPTH];
  alog_pkg::alog_entry_t hist [alog_pkg::HIST_DEPTH];
  alog_pkg::alog_entry_t next_hist [alog_pkg::HIST_DEPTH];
  alog_pkg::alog_entry_t pend_entry, next_pend_entry, new_entry;
  logic [15:0] remap_num [alog_pkg::REMAP_DEPTH];
  logic [15:0] next_remap_num [alog_pkg::REMAP_DEPTH];
  logic [1:0] remap_type [alog_pkg::REMAP_DEPTH];
  logic [1:0] next_remap_type [alog_pkg::REMAP_DEPTH];
  alog_state_t state, next_state;
  logic [2:0] scan, next_scan;
  logic [3:0] wp, next_wp, fill, next_fill;
  logic pend, next_pend;
  logic [15:0] alarm_counter_param, next_alarm_counter_param;
  logic [15:0] latest_alarm_code, next_latest_alarm_code;
  logic [5:0] sel, next_sel;
  logic next_alarm_ready, next_alarm_active, next_fault_raise;
  logic [15:0] next_fault_code;
  logic any_removed, counter_clear;

  // AXI state
  logic aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_word;
  logic rd_ok, do_write;
  alog_pkg::alog_entry_t sel_entry;
  logic [4:0] remap_w_idx, remap_r_idx;
  logic [31:0] sel_merged, remap_merged;

  // LED state
  logic [20:0] tick_cnt, next_tick_cnt;
  logic [5:0] phase, next_phase;
  logic next_bf_red, next_bf_green, next_rdy_red, next_rdy_green;
  logic p_slow, p_fast, p_single, p_double, p_var;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] remap_index(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - alog_pkg::REMAP_OFF;
    return d[6:2];
  endfunction

  // Upper bound on the full address, so aliases above the table miss
  function automatic logic is_remap(input logic [7:0] addr);
    return addr >= alog_pkg::REMAP_OFF && addr[1:0] == 2'h0 &&
      addr < alog_pkg::REMAP_OFF + 8'(4 * alog_pkg::REMAP_DEPTH);
  endfunction

  // Blink pattern: on during the first half of each full period
  function automatic logic blink(input logic [5:0] ph, input int half);
    return ((int'(ph) / half) % 2) == 0;
  endfunction

  function automatic logic [1:0] remap_lookup(input logic [15:0] code);
    logic [1:0] t;
    t = alog_pkg::MSG_ALARM;
    for (int i = 0; i < alog_pkg::REMAP_DEPTH; i++) begin
      if (remap_type[i] != 2'h0 && remap_num[i] == code) begin
        t = remap_type[i];
      end
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // Alarm log
  // ----------------------------------------------------------------
  always_comb begin
    next_abuf = abuf;
    next_hist = hist;
    next_pend_entry = pend_entry;
    next_state = state;
    next_scan = scan;
    next_wp = wp;
    next_fill = fill;
    next_pend = pend;
    next_alarm_counter_param = alarm_counter_param;
    next_latest_alarm_code = latest_alarm_code;
    next_fault_raise = 1'b0;
    next_fault_code = fault_code;
    any_removed = 1'b0;
    new_entry = {1'b1, 1'b0, alarm_code, alarm_value_fixed,
      alarm_value_float};
    case (state)
      LG_IDLE: begin
        // Cause gone, no acknowledge
        // Events refused while ready low, also right after reset
        if (alarm_gone && alarm_ready) begin
          for (int i = 0; i < alog_pkg::BUF_DEPTH; i++) begin
            if (abuf[i].valid && abuf[i].code == alarm_code) begin
              next_abuf[i].removed = 1'b1;
            end
          end
        end
        for (int i = 0; i < alog_pkg::BUF_DEPTH; i++) begin
          any_removed = any_removed | next_abuf[i].removed;
        end
        if (counter_clear) begin
          next_alarm_counter_param = 16'h0000;
          next_pend = 1'b0;
          next_scan = 3'h0;
          next_wp = 4'h0;
          next_state = LG_SCAN;
        end else if (alarm_raise && alarm_ready) begin
          case (remap_lookup(alarm_code))
            alog_pkg::MSG_FAULT: begin
              next_fault_raise = 1'b1;
              next_fault_code = alarm_code;
            end
            alog_pkg::MSG_NONE: begin
            end
            default: begin
              next_alarm_counter_param = alarm_counter_param + 16'h0001;
              next_latest_alarm_code = alarm_code;
              if (fill < 4'(alog_pkg::BUF_DEPTH)) begin
                next_abuf[fill[2:0]] = new_entry;
                next_fill = fill + 4'h1;
              end else if (any_removed) begin
                next_pend = 1'b1;
                next_pend_entry = new_entry;
                next_scan = 3'h0;
                next_wp = 4'h0;
                next_state = LG_SCAN;
              end else begin
                next_abuf[alog_pkg::OVERWRITE_IDX] =
                  abuf[alog_pkg::BUF_DEPTH - 1];
                next_abuf[alog_pkg::BUF_DEPTH - 1] = new_entry;
              end
            end
          endcase
        end
      end
      LG_SCAN: begin
        // Oldest first, so the youngest ends at the history head
        if (abuf[scan].valid && abuf[scan].removed) begin
          for (int k = alog_pkg::HIST_DEPTH - 1; k > 0; k--) begin
            next_hist[k] = hist[k - 1];
          end
          next_hist[0] = abuf[scan];
        end else if (abuf[scan].valid) begin
          next_abuf[wp[2:0]] = abuf[scan];
          next_wp = wp + 4'h1;
        end
        if (scan == 3'(alog_pkg::BUF_DEPTH - 1)) begin
          next_state = LG_FINISH;
        end else begin
          next_scan = scan + 3'h1;
        end
      end
      LG_FINISH: begin
        for (int i = 0; i < alog_pkg::BUF_DEPTH; i++) begin
          if (4'(i) >= wp) begin
            next_abuf[i] = '0;
          end
        end
        next_fill = wp;
        // Transfer freed at least one slot, so wp is below eight
        if (pend) begin
          next_abuf[wp[2:0]] = pend_entry;
          next_fill = wp + 4'h1;
          next_pend = 1'b0;
        end
        next_state = LG_IDLE;
      end
      default: next_state = LG_IDLE;
    endcase
    next_alarm_ready = next_state == LG_IDLE;
    next_alarm_active = 1'b0;
    for (int i = 0; i < alog_pkg::BUF_DEPTH; i++) begin
      if (next_abuf[i].valid && !next_abuf[i].removed) begin
        next_alarm_active = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < alog_pkg::BUF_DEPTH; i++) begin
        abuf[i] <= '0;
      end
      for (int k = 0; k < alog_pkg::HIST_DEPTH; k++) begin
        hist[k] <= '0;
      end
      pend_entry <= '0;
      state <= LG_IDLE;
      scan <= 3'h0;
      wp <= 4'h0;
      fill <= 4'h0;
      pend <= 1'b0;
      alarm_counter_param <= 16'h0000;
      latest_alarm_code <= 16'h0000;
      alarm_ready <= 1'b0;
      alarm_active <= 1'b0;
      fault_raise <= 1'b0;
      fault_code <= 16'h0000;
    end else begin
      abuf <= next_abuf;
      hist <= next_hist;
      pend_entry <= next_pend_entry;
      state <= next_state;
      scan <= next_scan;
      wp <= next_wp;
      fill <= next_fill;
      pend <= next_pend;
      alarm_counter_param <= next_alarm_counter_param;
      latest_alarm_code <= next_latest_alarm_code;
      alarm_ready <= next_alarm_ready;
      alarm_active <= next_alarm_active;
      fault_raise <= next_fault_raise;
      fault_code <= next_fault_code;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Writes wait for an idle log with no event, so a counter clear
  // never collides with an alarm being taken.
  assign do_write = aw_hold && w_hold && !s_bvalid && state == LG_IDLE &&
    !alarm_raise && !alarm_gone;
  assign counter_clear = do_write && aw_addr == alog_pkg::COUNT_OFF &&
    w_data == 32'h0000_0000;
  assign remap_w_idx = remap_index(aw_addr);
  assign remap_r_idx = remap_index(s_araddr);
  assign sel_merged = merge({26'h0, sel}, w_data, w_strb);
  assign remap_merged = merge({14'h0, remap_type[remap_w_idx],
    remap_num[remap_w_idx]}, w_data, w_strb);
  assign sel_entry = (sel < 6'(alog_pkg::HIST_BASE)) ? abuf[sel[2:0]] :
    hist[sel - 6'(alog_pkg::HIST_BASE)];

  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold = w_hold;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_bvalid && !s_bready;
    next_bresp = s_bresp;
    next_sel = sel;
    next_remap_num = remap_num;
    next_remap_type = remap_type;
    if (s_awvalid && s_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_wdata;
      next_w_strb = s_wstrb;
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = alog_pkg::RESP_OKAY;
      if (aw_addr == alog_pkg::SEL_OFF) begin
        next_sel = sel_merged[5:0];
      end else if (is_remap(aw_addr)) begin
        next_remap_num[remap_w_idx] = remap_merged[15:0];
        next_remap_type[remap_w_idx] =
          remap_merged[alog_pkg::REMAP_TYPE_LSB +: 2];
      end else if (aw_addr != alog_pkg::COUNT_OFF) begin
        next_bresp = alog_pkg::RESP_SLVERR;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_araddr)
      alog_pkg::STATUS_OFF: rd_word[alog_pkg::STATUS_ALARM_BIT] = alarm_active;
      alog_pkg::COUNT_OFF: rd_word = {16'h0000, alarm_counter_param};
      alog_pkg::LATEST_OFF: rd_word = {16'h0000, latest_alarm_code};
      alog_pkg::SEL_OFF: rd_word = {26'h0, sel};
      alog_pkg::ECODE_OFF: begin
        rd_word[15:0] = sel_entry.code;
        rd_word[alog_pkg::ECODE_REMOVED_BIT] = sel_entry.removed;
        rd_word[alog_pkg::ECODE_VALID_BIT] = sel_entry.valid;
      end
      alog_pkg::EFIX_OFF: rd_word = sel_entry.fixed;
      alog_pkg::EFLT_OFF: rd_word = sel_entry.flt;
      default: begin
        if (is_remap(s_araddr)) begin
          rd_word = {14'h0, remap_type[remap_r_idx], remap_num[remap_r_idx]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
    next_rvalid = s_rvalid && !s_rready;
    next_rdata = s_rdata;
    next_rresp = s_rresp;
    if (s_arvalid && s_arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_ok ? alog_pkg::RESP_OKAY : alog_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_hold <= 1'b0;
      w_data <= alog_pkg::REG_RESET;
      w_strb <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= alog_pkg::RESP_OKAY;
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= alog_pkg::REG_RESET;
      s_rresp <= alog_pkg::RESP_OKAY;
      sel <= 6'h00;
      for (int i = 0; i < alog_pkg::REMAP_DEPTH; i++) begin
        remap_num[i] <= 16'h0000;
        remap_type[i] <= 2'h0;
      end
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold <= next_w_hold;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_awready <= !next_aw_hold;
      s_wready <= !next_w_hold;
      s_bvalid <= next_bvalid;
      s_bresp <= next_bresp;
      s_arready <= !next_rvalid;
      s_rvalid <= next_rvalid;
      s_rdata <= next_rdata;
      s_rresp <= next_rresp;
      sel <= next_sel;
      remap_num <= next_remap_num;
      remap_type <= next_remap_type;
    end
  end

  // ----------------------------------------------------------------
  // LED patterns
  // ----------------------------------------------------------------
  always_comb begin
    next_tick_cnt = tick_cnt + 21'h1;
    next_phase = phase;
    if (tick_cnt == 21'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 21'h0;
      next_phase = (phase == 6'(alog_pkg::FRAME_TICKS - 1)) ? 6'h0 :
        phase + 6'h1;
    end
    p_slow = blink(phase, alog_pkg::SLOW_HALF);
    p_fast = blink(phase, alog_pkg::FAST_HALF);
    p_single = phase < 6'(alog_pkg::FLASH_TICKS);
    p_double = p_single || (phase >= 6'(2 * alog_pkg::FLASH_TICKS) &&
      phase < 6'(3 * alog_pkg::FLASH_TICKS));
    // Rate changes from fast to slow halfway through each frame
    p_var = (phase < 6'(alog_pkg::FRAME_TICKS / 2)) ? p_fast : p_slow;
    next_bf_red = 1'b0;
    next_bf_green = 1'b0;
    next_rdy_red = 1'b0;
    next_rdy_green = 1'b1;
    if (fw_updating) begin
      next_bf_red = p_var;
      next_bf_green = p_var;
      next_rdy_red = 1'b1;
      next_rdy_green = 1'b0;
    end else if (fw_wait_power) begin
      next_bf_red = p_slow;
      next_rdy_red = p_slow;
      next_rdy_green = 1'b0;
    end else if (fw_failed || bad_card) begin
      next_bf_red = p_fast;
      next_rdy_red = p_fast;
      next_rdy_green = 1'b0;
    end else if (no_bus) begin
      next_bf_red = 1'b1;
    end else if (error_control_event) begin
      next_bf_red = p_double;
    end else if (alarm_limit) begin
      next_bf_red = p_single;
    end else begin
      case (can_state)
        alog_pkg::CAN_OPER: next_bf_green = 1'b1;
        alog_pkg::CAN_PREOP: next_bf_green = p_fast;
        alog_pkg::CAN_STOPPED: next_bf_green = p_single;
        default: next_bf_green = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_cnt <= 21'h0;
      phase <= 6'h0;
      bus_fault_led_red <= 1'b0;
      bus_fault_led_green <= 1'b0;
      ready_led_red <= 1'b0;
      ready_led_green <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      phase <= next_phase;
      bus_fault_led_red <= next_bf_red;
      bus_fault_led_green <= next_bf_green;
      ready_led_red <= next_rdy_red;
      ready_led_green <= next_rdy_green;
    end
  end

endmodule

`default_nettype wire

// [alog_bus_model.sv]
// Bus controller and device state levels for the LED logic.
// Assumes the bench steps mode; levels hold between steps.
`timescale 1ns/1ps
`default_nettype none
module alog_bus_model (
  // Scenario select
  input wire logic [3:0] mode,
  // Levels toward the block
  output logic [1:0] can_state,
  output logic no_bus,
  output logic alarm_limit,
  output logic error_control_event,
  output logic fw_wait_power,
  output logic fw_updating,
  output logic fw_failed,
  output logic bad_card
);
  // Codes 0 to 2 are bus states; codes 3 to 9 raise one level each
  assign can_state = mode[1:0];
  assign no_bus = mode == 4'h3;
  assign alarm_limit = mode == 4'h4;
  assign error_control_event = mode == 4'h5;
  assign fw_wait_power = mode == 4'h6;
  assign fw_updating = mode == 4'h7;
  assign fw_failed = mode == 4'h8;
  assign bad_card = mode == 4'h9;
endmodule
`default_nettype wire

// [alog_asserts.sv]
// Port checks of the alarm log and LED block.
// Assumes binding to alog_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module alog_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Log and states
  input wire logic alarm_ready,
  input wire logic alarm_raise,
  input wire logic [15:0] alarm_code,
  input wire logic fault_raise,
  input wire logic [15:0] fault_code,
  input wire logic [1:0] can_state,
  input wire logic no_bus,
  input wire logic alarm_limit,
  input wire logic error_control_event,
  input wire logic fw_updating,
  input wire logic fw_wait_power,
  input wire logic fw_failed,
  input wire logic bad_card,
  // LEDs
  input wire logic bus_fault_led_red,
  input wire logic bus_fault_led_green,
  input wire logic ready_led_red,
  input wire logic ready_led_green
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic fw_any;
  logic quiet;
  assign fw_any = fw_updating | fw_wait_power | fw_failed | bad_card;
  assign quiet = !fw_any & !no_bus & !error_control_event & !alarm_limit;
  a_fault_cause: assert property (fault_raise |->
    $past(alarm_raise) && $past(alarm_ready) &&
    fault_code == $past(alarm_code))
    else $error("fault without taken alarm");
  a_ready_green: assert property ((!fw_any)[*2] |=>
    ready_led_green && !ready_led_red) else $error("ready not green");
  a_oper_green: assert property ((quiet && can_state ==
    alog_pkg::CAN_OPER)[*2] |=> bus_fault_led_green && !bus_fault_led_red)
    else $error("bus led not green");
  a_nobus_red: assert property ((no_bus && !fw_any)[*2] |=>
    bus_fault_led_red && !bus_fault_led_green) else $error("no bus red");
  a_update_red: assert property (fw_updating[*2] |=>
    ready_led_red && !ready_led_green) else $error("update not red");
  a_wait_red: assert property ((fw_wait_power && !fw_updating)[*2] |=>
    !ready_led_green && !bus_fault_led_green) else $error("wait green");
  a_bad_fast: assert property (((fw_failed | bad_card) &&
    !fw_updating && !fw_wait_power)[*2] |=> !ready_led_green &&
    !bus_fault_led_green) else $error("bad card green");
  a_scan_len: assert property ($fell(alarm_ready) |->
    ##[1:9] alarm_ready) else $error("log busy too long");
  cover property (fault_raise);
  cover property ($fell(alarm_ready));
  cover property (fw_updating && ready_led_red);
endmodule
bind alog_top alog_asserts chk (.*);
`default_nettype wire

// [alog_tb.sv]
// Bench for alarm log, history, remap table and LEDs.
// Assumes alog_top, the state model and a short LED tick.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hF, mode = 4'h2;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic alarm_raise = 1'b0, alarm_gone = 1'b0;
  logic [15:0] alarm_code = 16'h0, fault_code;
  logic [31:0] alarm_value_fixed = 32'h0, alarm_value_float = 32'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, alarm_ready;
  logic alarm_active, fault_raise, no_bus, alarm_limit, error_control_event;
  logic fw_updating, fw_wait_power, fw_failed, bad_card;
  logic bus_fault_led_red, bus_fault_led_green, ready_led_red, ready_led_green;
  logic [1:0] s_bresp, s_rresp, can_state;
  logic [31:0] s_rdata, lf, lt;
  logic [33:0] er;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  int mismatches = 0, total_checks = 0, i;
  alog_bus_model bus_m (.*);
  alog_top #(.TICK_CYCLES(4)) uut (.*);
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] ew(input logic rm, input logic [15:0] c);
    return {14'h0, 1'b1, rm, c};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = alog_pkg::RESP_OKAY);
    exp_b.push_back(r);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_awvalid || s_wvalid);
    do @(posedge clk); while (!s_bvalid);
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = alog_pkg::RESP_OKAY);
    exp_r.push_back({r, d});
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge clk); while (!s_rvalid);
    s_rready <= 1'b0;
  endtask
  task automatic ent(input logic [7:0] x, input logic [31:0] d);
    wr(alog_pkg::SEL_OFF, {24'h0, x});
    rd(alog_pkg::ECODE_OFF, d);
  endtask
  task automatic ev(input logic g, input logic [15:0] c);
    lf = $urandom;
    lt = $urandom;
    @(posedge clk);
    alarm_gone <= g;
    alarm_raise <= !g;
    alarm_code <= c;
    alarm_value_fixed <= lf;
    alarm_value_float <= lt;
    do @(posedge clk); while (!alarm_ready);
    alarm_raise <= 1'b0;
    alarm_gone <= 1'b0;
  endtask
  task automatic conclude;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (s_rvalid && s_rready && exp_r.size() > 0) begin
      er = exp_r.pop_front();
      total_checks++;
      if ({s_rresp, s_rdata} !== er) begin
        mismatches++;
        $display("[FAIL] %0t read %h expected %h", $time, s_rdata, er);
      end
    end
    if (s_bvalid && s_bready && exp_b.size() > 0) begin
      total_checks++;
      if (s_bresp !== exp_b.pop_front()) begin
        mismatches++;
        $display("[FAIL] %0t write response %h", $time, s_bresp);
      end
    end
  end
  initial begin
    #800000;
    mismatches++;
    conclude;
  end
  initial begin
    void'($urandom(78891));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(alog_pkg::COUNT_OFF, 32'h0);
    for (i = 1; i <= 8; i++) ev(1'b0, i[15:0]);
    ent(8'h07, ew(1'b0, 16'h8));
    rd(alog_pkg::EFIX_OFF, lf);
    rd(alog_pkg::EFLT_OFF, lt);
    rd(alog_pkg::STATUS_OFF, 32'h80);
    ev(1'b0, 16'h9);
    ent(8'h06, ew(1'b0, 16'h8));
    ent(8'h07, ew(1'b0, 16'h9));
    ev(1'b1, 16'h2);
    ev(1'b1, 16'h5);
    ent(8'h01, ew(1'b1, 16'h2));
    ev(1'b0, 16'hA);
    ent(8'h08, ew(1'b1, 16'h5));
    ent(8'h09, ew(1'b1, 16'h2));
    ent(8'h01, ew(1'b0, 16'h3));
    ent(8'h06, ew(1'b0, 16'hA));
    wr(alog_pkg::REMAP_OFF, 32'h0003_0077);
    wr(alog_pkg::REMAP_OFF + 8'h04, 32'h0001_0066);
    ev(1'b0, 16'h77);
    ev(1'b0, 16'h66);
    rd(alog_pkg::COUNT_OFF, 32'hA);
    rd(alog_pkg::LATEST_OFF, 32'hA);
    total_checks++;
    if (fault_code !== 16'h66) begin
      mismatches++;
      $display("[FAIL] %0t fault code %h", $time, fault_code);
    end
    for (i = 1; i <= 10; i++) ev(1'b1, i[15:0]);
    rd(alog_pkg::STATUS_OFF, 32'h0);
    wr(alog_pkg::COUNT_OFF, 32'h0);
    rd(alog_pkg::COUNT_OFF, 32'h0);
    ent(8'h08, ew(1'b1, 16'hA));
    ent(8'h10, ew(1'b1, 16'h2));
    for (i = 0; i < 96; i++) begin
      ev(i[3], {13'h0020, i[2:0]});
      if (i[3:0] == 4'hF) wr(alog_pkg::COUNT_OFF, 32'h0);
    end
    ent(8'h3F, ew(1'b1, 16'h5));
    wr(alog_pkg::STATUS_OFF, 32'h1, alog_pkg::RESP_SLVERR);
    rd(8'hFC, 32'h0, alog_pkg::RESP_SLVERR);
    for (i = 0; i < 10; i++) begin
      mode <= i[3:0];
      repeat (100) @(posedge clk);
    end
    conclude;
  end
endmodule
`default_nettype wire
